// ### hcwt_cfg.svh
// offsets, reset values and timing counts for the code word transmitter
`ifndef HCWT_CFG_SVH
`define HCWT_CFG_SVH

// system clock and timing base
`define HCWT_CLK_MHZ 100
`define HCWT_TICK_US 50
`define HCWT_TICK_CYC (`HCWT_TICK_US * `HCWT_CLK_MHZ)

// register byte offsets
`define HCWT_OFS_ENC0 8'h00
`define HCWT_OFS_ENC1 8'h04
`define HCWT_OFS_COM 8'h08
`define HCWT_OFS_CMD 8'h0C
`define HCWT_OFS_HOP 8'h10
`define HCWT_OFS_FIX 8'h14
`define HCWT_OFS_STAT 8'h18

// command bit positions
`define HCWT_CMD_PRESS 0
`define HCWT_CMD_HELD 1

// reset values: encoder configs all zero, one minimum code word
`define HCWT_ENC_RST 9'h000
`define HCWT_COM_RST 10'h040

// times in microseconds, tick counts derived (all divide exactly)
`define HCWT_TE_US 100
`define HCWT_TE_T (`HCWT_TE_US / `HCWT_TICK_US)
`define HCWT_GUARD1_US 6400
`define HCWT_GUARD2_US 51200
`define HCWT_GUARD3_US 102400
`define HCWT_WAKE1_US 50000
`define HCWT_WAKE2_US 75000
`define HCWT_WAKE3_US 100000
`define HCWT_LED_ON0_US 50000
`define HCWT_LED_ON1_US 100000
`define HCWT_LED_OFF_US 500000
`define HCWT_QWIN_US 2000000
`define HCWT_SETTLE_ASK_US 1000
`define HCWT_SETTLE_FSK_US 2000
`define HCWT_HDR_SHORT_TE 4
`define HCWT_HDR_LONG_TE 10
`define HCWT_PRE_PULSES 12

`endif

// ### hcwt_pkg.sv
// types shared by the code word transmitter
package hcwt_pkg;

  // data bit modulation formats
  typedef enum logic [1:0] {
    MOD_PWM = 2'h0,
    MOD_MAN = 2'h1,
    MOD_VPWM = 2'h2,
    MOD_PPM = 2'h3
  } hcwt_mod_t;

  // per-encoder settings, guard time in the low bits
  typedef struct packed {
    logic queue_en;
    logic marker_en;
    hcwt_mod_t modulation;
    logic header_long;
    logic [1:0] element_period;
    logic [1:0] guard_time;
  } hcwt_enc_cfg_t;

  // settings shared by both encoders
  typedef struct packed {
    logic [3:0] min_words;
    logic led_blink_low;
    logic led_on_long;
    logic pll_fsk;
    logic rf_en_sel;
    logic [1:0] wakeup;
  } hcwt_com_cfg_t;

  // one output segment: level, length in elements, second half follows
  typedef struct packed {
    logic lvl;
    logic [1:0] len;
    logic more;
  } hcwt_seg_t;

  // transmit sequencer states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_SETTLE = 7'h02,
    S_WAKE = 7'h04,
    S_PRE = 7'h08,
    S_HDR = 7'h10,
    S_DATA = 7'h20,
    S_GUARD = 7'h40
  } hcwt_state_t;

endpackage

// ### hcwt_tx.sv
// code word framer, modulator, rf enable and indicator control
`include "hcwt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hcwt_tx #(
  parameter int TICK_CYCLES = `HCWT_TICK_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic ENC_SEL_I,
  input wire logic LOW_VOLT_I,
  output logic DATA_O,
  output logic RF_EN_O,
  output logic RF_EN_OE_O,
  output logic LED_O,
  output logic LED_OE_O
);
  import hcwt_pkg::*;

  // byte lane merge for register writes
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // two-bit crc over the first 65 bits, first sent bit first
  function automatic logic [1:0] crc2(input logic [64:0] d);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 0; i < 65; i++) begin
      c = {c[0] ^ d[i], c[0] ^ d[i] ^ c[1]};
    end
    return c;
  endfunction

  // segment shape of one data bit per modulation
  function automatic hcwt_seg_t seg_of(input hcwt_mod_t m, input logic b, input logic k, input logic vp);
    hcwt_seg_t s;
    s = '{lvl: 1'b0, len: 2'h1, more: 1'b0};
    case (m)
      MOD_PWM: s = k ? '{1'b0, b ? 2'h2 : 2'h1, 1'b0} : '{1'b1, b ? 2'h1 : 2'h2, 1'b1};
      MOD_MAN: s = '{k ? b : ~b, 2'h1, ~k};
      MOD_VPWM: s = '{vp, b ? 2'h2 : 2'h1, 1'b0};
      default: s = k ? '{1'b0, b ? 2'h2 : 2'h1, 1'b0} : '{1'b1, 2'h1, 1'b1};
    endcase
    return s;
  endfunction

  // guard gap in ticks, 0 means none
  function automatic logic [15:0] guard_ticks(input logic [1:0] sel);
    case (sel)
      2'h1: return 16'(`HCWT_GUARD1_US / `HCWT_TICK_US);
      2'h2: return 16'(`HCWT_GUARD2_US / `HCWT_TICK_US);
      2'h3: return 16'(`HCWT_GUARD3_US / `HCWT_TICK_US);
      default: return 16'h0000;
    endcase
  endfunction

  // wake-up burst length in ticks, 0 means none
  function automatic logic [15:0] wake_ticks(input logic [1:0] sel);
    case (sel)
      2'h1: return 16'(`HCWT_WAKE1_US / `HCWT_TICK_US);
      2'h2: return 16'(`HCWT_WAKE2_US / `HCWT_TICK_US);
      2'h3: return 16'(`HCWT_WAKE3_US / `HCWT_TICK_US);
      default: return 16'h0000;
    endcase
  endfunction

  logic enc_sel_m, enc_sel_s; // select pin synchroniser
  logic low_voltage_flag_m, low_voltage_flag_s; // low supply synchroniser
  logic [12:0] tick_cnt; // divider for the 50 us tick
  logic tick; // one-cycle tick enable
  hcwt_enc_cfg_t enc_cfg [2]; // per-encoder settings
  hcwt_com_cfg_t com_cfg; // shared settings
  logic [31:0] hop_reg, fix_reg; // code portions written by software
  logic held; // button still held
  logic press_req; // one-cycle press event
  logic wr_fire, rd_fire; // bus access completes this edge
  logic [31:0] rd_val; // read mux
  hcwt_state_t state;
  logic act_enc; // encoder of the current press
  logic [31:0] frame_hop, frame_fix; // latched word content
  logic frame_low_voltage_flag;
  logic [1:0] frame_q;
  logic [1:0] queue_cnt, next_queue; // press queue counter
  logic [15:0] press_age; // ticks since last press start
  logic press_seen;
  logic pending; // second press waiting
  logic [3:0] word_cnt; // words sent for this press
  logic [15:0] seg_left, wake_left; // tick counters
  logic [4:0] half_cnt; // preamble half pulses
  logic [6:0] bit_idx;
  logic seg_k, vp; // second half flag, vpwm level
  logic lvl, rf_en; // data and rf enable levels
  logic led_lit, led_phase_off, led_once;
  logic [15:0] led_cnt;
  hcwt_enc_cfg_t cfg; // active encoder settings
  logic enc_sel_eff;
  logic [15:0] te;
  logic [68:0] payload;
  logic [70:0] wbits;
  logic [6:0] wlen;
  hcwt_seg_t cur_seg, half2_seg, nbit_seg;
  logic seg_done, guard_done, take_pend, more_words, go_pre, go_idle, abort_word;
  logic [4:0] next_cnt;
  logic [15:0] settle_t, led_on_t;

  // pin synchronisers
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      enc_sel_m <= 1'b0;
      enc_sel_s <= 1'b0;
      low_voltage_flag_m <= 1'b0;
      low_voltage_flag_s <= 1'b0;
    end else begin
      enc_sel_m <= ENC_SEL_I;
      enc_sel_s <= enc_sel_m;
      low_voltage_flag_m <= LOW_VOLT_I;
      low_voltage_flag_s <= low_voltage_flag_m;
    end
  end

  // tick divider, all timing counts in ticks
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tick_cnt <= 13'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == 13'(TICK_CYCLES - 1)) begin
      tick_cnt <= 13'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 13'h0001;
      tick <= 1'b0;
    end
  end

  // avalon handshake: waitrequest low for one cycle, second edge
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
    end else if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O <= AVS_READ_I ? rd_val : 32'h00000000;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  assign wr_fire = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_fire = AVS_READ_I && !AVS_WAITREQUEST_O;

  // read mux, unmapped reads return zero
  always_comb begin
    rd_val = 32'h00000000;
    case (AVS_ADDRESS_I)
      `HCWT_OFS_ENC0: rd_val = 32'(enc_cfg[0]);
      `HCWT_OFS_ENC1: rd_val = 32'(enc_cfg[1]);
      `HCWT_OFS_COM: rd_val = 32'(com_cfg);
      `HCWT_OFS_CMD: rd_val = {30'h0, held, 1'b0};
      `HCWT_OFS_HOP: rd_val = hop_reg;
      `HCWT_OFS_FIX: rd_val = fix_reg;
      `HCWT_OFS_STAT: rd_val = {16'h0000, led_lit, pending, act_enc, low_voltage_flag_s, queue_cnt,
                                word_cnt, state != S_IDLE, rf_en, lvl, 3'h0};
      default: rd_val = 32'h00000000;
    endcase
  end

  // register writes and press event, unmapped writes dropped
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      enc_cfg[0] <= `HCWT_ENC_RST;
      enc_cfg[1] <= `HCWT_ENC_RST;
      com_cfg <= `HCWT_COM_RST;
      hop_reg <= 32'h00000000;
      fix_reg <= 32'h00000000;
      held <= 1'b0;
      press_req <= 1'b0;
    end else begin
      press_req <= 1'b0;
      if (wr_fire) begin
        case (AVS_ADDRESS_I)
          `HCWT_OFS_ENC0: enc_cfg[0] <= 9'(merge32(32'(enc_cfg[0]), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
          `HCWT_OFS_ENC1: enc_cfg[1] <= 9'(merge32(32'(enc_cfg[1]), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
          `HCWT_OFS_COM: com_cfg <= 10'(merge32(32'(com_cfg), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
          `HCWT_OFS_HOP: hop_reg <= merge32(hop_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `HCWT_OFS_FIX: fix_reg <= merge32(fix_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `HCWT_OFS_CMD: begin
            if (AVS_BYTEENABLE_I[0]) begin
              press_req <= AVS_WRITEDATA_I[`HCWT_CMD_PRESS];
              held <= AVS_WRITEDATA_I[`HCWT_CMD_HELD];
            end
          end
          default: held <= held;
        endcase
      end
    end
  end

  // word content, timing and next segments for the active encoder
  always_comb begin
    cfg = enc_cfg[act_enc];
    // rf enable mode forces the first encoder
    enc_sel_eff = com_cfg.rf_en_sel ? 1'b0 : enc_sel_s;
    te = 16'(`HCWT_TE_T) << cfg.element_period;
    // crc over hopping, fixed and low voltage bits
    payload = {cfg.queue_en ? frame_q : 2'h0, crc2({frame_low_voltage_flag, frame_fix, frame_hop}),
               frame_low_voltage_flag, frame_fix, frame_hop};
    // 67 bits without queue, adds two
    wlen = cfg.queue_en ? 7'd69 : 7'd67;
    if (cfg.marker_en) begin
      wbits = {1'b0, payload, 1'b1} | (71'h1 << (wlen + 7'd1));
      wlen = wlen + 7'd2;
    end else begin
      wbits = 71'(payload);
    end
    cur_seg = seg_of(cfg.modulation, wbits[bit_idx], seg_k, vp);
    half2_seg = seg_of(cfg.modulation, wbits[bit_idx], 1'b1, vp);
    nbit_seg = seg_of(cfg.modulation, wbits[7'(bit_idx + 7'd1)], 1'b0, ~vp);
    // pll style sets the settling wait
    settle_t = com_cfg.pll_fsk ? 16'(`HCWT_SETTLE_FSK_US / `HCWT_TICK_US) :
                                 16'(`HCWT_SETTLE_ASK_US / `HCWT_TICK_US);
    led_on_t = com_cfg.led_on_long ? 16'(`HCWT_LED_ON1_US / `HCWT_TICK_US) :
                                     16'(`HCWT_LED_ON0_US / `HCWT_TICK_US);
  end

  // sequencing decisions
  always_comb begin
    seg_done = tick && (seg_left == 16'h0000);
    guard_done = (state == S_GUARD) && ((cfg.guard_time == 2'h0) || seg_done);
    next_cnt = {1'b0, word_cnt} + 5'h01;
    more_words = (next_cnt < {1'b0, com_cfg.min_words}) || held;
    // second press waits for the minimum words unless queueing is enabled
    take_pend = guard_done && pending && (cfg.queue_en || (next_cnt >= {1'b0, com_cfg.min_words}));
    // queued press cuts the word short
    abort_word = press_req && !pending && cfg.queue_en &&
                 ((state == S_PRE) || (state == S_HDR) || (state == S_DATA));
    go_pre = ((state == S_SETTLE) && seg_done && (com_cfg.wakeup == 2'h0)) ||
             ((state == S_WAKE) && (wake_left == 16'h0000)) ||
             (guard_done && (take_pend || more_words));
    // a press in the final guard cycle keeps the link up, set wins over the stop
    go_idle = guard_done && !take_pend && !more_words && !press_req;
    next_queue = (press_seen && press_age < 16'(`HCWT_QWIN_US / `HCWT_TICK_US)) ?
                 ((queue_cnt == 2'h3) ? 2'h3 : queue_cnt + 2'h1) : 2'h0;
  end

  // press age and queue counter
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      press_age <= 16'h0000;
      press_seen <= 1'b0;
      queue_cnt <= 2'h0;
    end else if (press_req) begin
      press_age <= 16'h0000;
      press_seen <= 1'b1;
      queue_cnt <= next_queue;
    end else if (tick && press_age != 16'hFFFF) begin
      press_age <= press_age + 16'h0001;
    end
  end

  // main transmit sequencer
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= S_IDLE;
      act_enc <= 1'b0;
      frame_hop <= 32'h00000000;
      frame_fix <= 32'h00000000;
      frame_low_voltage_flag <= 1'b0;
      frame_q <= 2'h0;
      pending <= 1'b0;
      word_cnt <= 4'h0;
      seg_left <= 16'h0000;
      wake_left <= 16'h0000;
      half_cnt <= 5'h00;
      bit_idx <= 7'h00;
      seg_k <= 1'b0;
      vp <= 1'b1;
      lvl <= 1'b0;
      rf_en <= 1'b0;
    end else begin
      if (tick && seg_left != 16'h0000) begin
        seg_left <= seg_left - 16'h0001;
      end
      if (tick && wake_left != 16'h0000) begin
        wake_left <= wake_left - 16'h0001;
      end
      // a second press is remembered, more are ignored
      if (press_req && state != S_IDLE && !pending) begin
        pending <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (press_req) begin
            act_enc <= enc_sel_eff;
            frame_hop <= hop_reg;
            frame_fix <= fix_reg;
            frame_low_voltage_flag <= low_voltage_flag_s;
            frame_q <= next_queue;
            word_cnt <= 4'h0;
            // rf enable rises before the first pulse
            rf_en <= 1'b1;
            seg_left <= settle_t;
            state <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (seg_done && com_cfg.wakeup != 2'h0) begin
            wake_left <= wake_ticks(com_cfg.wakeup);
            lvl <= 1'b1;
            seg_left <= te - 16'h0001;
            state <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (seg_done && wake_left != 16'h0000) begin
            lvl <= ~lvl;
            seg_left <= te - 16'h0001;
          end
        end
        S_PRE: begin
          if (seg_done) begin
            if (half_cnt == 5'(2 * `HCWT_PRE_PULSES - 1)) begin
              // header of four or ten elements
              lvl <= 1'b0;
              seg_left <= (cfg.header_long ? 16'(`HCWT_HDR_LONG_TE) : 16'(`HCWT_HDR_SHORT_TE)) * te - 16'h0001;
              state <= S_HDR;
            end else begin
              half_cnt <= half_cnt + 5'h01;
              lvl <= ~lvl;
              seg_left <= te - 16'h0001;
            end
          end
        end
        S_HDR: begin
          if (seg_done) begin
            lvl <= cur_seg.lvl;
            seg_left <= ((cur_seg.len == 2'h2) ? (te << 1) : te) - 16'h0001;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (seg_done) begin
            if (cur_seg.more && !seg_k) begin
              seg_k <= 1'b1;
              lvl <= half2_seg.lvl;
              seg_left <= ((half2_seg.len == 2'h2) ? (te << 1) : te) - 16'h0001;
            end else if (bit_idx == wlen - 7'd1) begin
              // selected guard gap after each word
              lvl <= 1'b0;
              seg_left <= guard_ticks(cfg.guard_time) - 16'h0001;
              state <= S_GUARD;
            end else begin
              bit_idx <= bit_idx + 7'h01;
              seg_k <= 1'b0;
              vp <= ~vp;
              lvl <= nbit_seg.lvl;
              seg_left <= ((nbit_seg.len == 2'h2) ? (te << 1) : te) - 16'h0001;
            end
          end
        end
        S_GUARD: begin
          if (go_idle) begin
            // rf enable falls after the final guard
            rf_en <= 1'b0;
            pending <= 1'b0;
            state <= S_IDLE;
          end else if (guard_done && !take_pend) begin
            word_cnt <= (word_cnt == 4'hF) ? 4'hF : next_cnt[3:0];
          end
        end
        default: state <= S_IDLE;
      endcase
      if (abort_word) begin
        lvl <= 1'b0;
        seg_left <= guard_ticks(cfg.guard_time) - 16'h0001;
        state <= S_GUARD;
      end
      // queued press takes over with a fresh word
      if (take_pend) begin
        frame_hop <= hop_reg;
        frame_fix <= fix_reg;
        frame_low_voltage_flag <= low_voltage_flag_s;
        frame_q <= queue_cnt;
        word_cnt <= 4'h0;
        pending <= 1'b0;
      end
      // each word starts with the preamble
      if (go_pre) begin
        half_cnt <= 5'h00;
        bit_idx <= 7'h00;
        seg_k <= 1'b0;
        vp <= 1'b1;
        lvl <= 1'b1;
        seg_left <= te - 16'h0001;
        state <= S_PRE;
      end
    end
  end

  // indicator: sinks while sending, blink on then fixed off time
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      led_lit <= 1'b0;
      led_phase_off <= 1'b0;
      led_once <= 1'b0;
      led_cnt <= 16'h0000;
    end else if (state == S_IDLE) begin
      led_lit <= 1'b0;
      led_phase_off <= 1'b0;
      led_once <= 1'b0;
      led_cnt <= 16'h0000;
    end else begin
      // low supply blocks or limits the blink
      // on time selectable, off time fixed
      led_lit <= !led_phase_off && (!low_voltage_flag_s || (com_cfg.led_blink_low && !led_once));
      if (tick) begin
        if (!led_phase_off && led_cnt == led_on_t - 16'h0001) begin
          led_phase_off <= 1'b1;
          led_cnt <= 16'h0000;
          led_once <= led_once | low_voltage_flag_s;
        end else if (led_phase_off && led_cnt == 16'(`HCWT_LED_OFF_US / `HCWT_TICK_US) - 16'h0001) begin
          led_phase_off <= 1'b0;
          led_cnt <= 16'h0000;
        end else begin
          led_cnt <= led_cnt + 16'h0001;
        end
      end
    end
  end

  // pin drivers, all from flip-flops
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RF_EN_OE_O <= 1'b0;
      LED_O <= 1'b0;
    end else begin
      // shared pin driven only in rf enable mode
      RF_EN_OE_O <= com_cfg.rf_en_sel;
      LED_O <= 1'b0;
    end
  end

  assign DATA_O = lvl;
  assign RF_EN_O = rf_en;
  assign LED_OE_O = led_lit;

endmodule

`default_nettype wire

// ### hcwt_tx_properties.sv
// port checker for the code word transmitter
`timescale 1ns/1ps
`default_nettype none
module hcwt_tx_properties #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic DATA_O,
  input wire logic RF_EN_O,
  input wire logic RF_EN_OE_O,
  input wire logic LED_O,
  input wire logic LED_OE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // a pending request is answered next cycle
  chk_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus request not answered");
  // answer lasts a single cycle
  chk_wait_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("waitrequest low too long");
  // no answer without a request
  chk_wait_idle: assert property (!(AVS_READ_I || AVS_WRITE_I) |=> AVS_WAITREQUEST_O) else $error("spurious answer");
  chk_led_sink: assert property (LED_O == 1'b0) else $error("indicator value not low");
  chk_led_idle: assert property (!RF_EN_O [*3] |-> !LED_OE_O) else $error("indicator lit while idle");
  chk_led_span: assert property ($rose(LED_OE_O) |=> LED_OE_O [*8]) else $error("indicator flash too short");
  chk_data_quiet: assert property (!RF_EN_O |-> !DATA_O) else $error("data sent without rf enable");
  chk_rf_settle: assert property ($rose(RF_EN_O) |-> !DATA_O [*8]) else $error("data before pll settle");
  chk_rf_tail: assert property ($fell(RF_EN_O) |-> !$past(DATA_O) && !$past(DATA_O, 2))
    else $error("rf enable dropped mid word");
  // pin role set by a write
  chk_oe_cause: assert property ($changed(RF_EN_OE_O) |-> $past(AVS_WRITE_I) || $past(AVS_WRITE_I, 2))
    else $error("pin role changed without write");
  cover property ($fell(RF_EN_O));
  cover property ($rose(LED_OE_O));
  cover property (!AVS_WAITREQUEST_O && AVS_WRITE_I);
endmodule
bind hcwt_tx hcwt_tx_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.CLK_SYS_I, .RESET_N_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WAITREQUEST_O, .DATA_O, .RF_EN_O, .RF_EN_OE_O, .LED_O, .LED_OE_O);
`default_nettype wire

// ### hcwt_rf_stage.sv
// rf stage model: counts keyed pulses and the pll settle gap
`timescale 1ns/1ps
`default_nettype none
module hcwt_rf_stage (
  input wire logic clk_i,
  input wire logic rf_en_i,
  input wire logic data_i,
  output int pulses_o,
  output int gap_o,
  output logic [63:0] bits_o
);
  int hi = 0; // cycles the current pulse has been high
  logic rf_q = 1'b0; // previous rf enable
  logic data_q = 1'b0; // previous data level
  logic seen = 1'b0; // first pulse arrived
  // restart on power up, count rising data edges and cycles before the first
  always_ff @(posedge clk_i) begin
    rf_q <= rf_en_i;
    data_q <= data_i;
    // pulse width decode: short high (under 1.5 elements of 8 cycles) is a one
    if (data_i) begin
      hi <= hi + 1;
    end else if (data_q) begin
      bits_o <= {bits_o[62:0], hi < 12};
      hi <= 0;
    end
    if (rf_en_i && !rf_q) begin
      pulses_o <= 0;
      gap_o <= 0;
      seen <= 1'b0;
    end else if (rf_en_i) begin
      if (data_i && !data_q) begin
        pulses_o <= pulses_o + 1;
        seen <= 1'b1;
      end
      if (!seen) begin
        gap_o <= gap_o + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the code word transmitter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLK_SYS_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic AVS_READ_I = 1'b0;
  logic AVS_WRITE_I = 1'b0;
  logic ENC_SEL_I = 1'b0;
  logic LOW_VOLT_I = 1'b0;
  logic [7:0] AVS_ADDRESS_I = 8'h00;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [3:0] AVS_BYTEENABLE_I = 4'hF;
  logic [31:0] AVS_READDATA_O, rd;
  logic [63:0] rf_bits;
  logic AVS_WAITREQUEST_O, DATA_O, RF_EN_O, RF_EN_OE_O, LED_O, LED_OE_O;
  logic led_q = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int pulses, gap;
  int flashes = 0;
  hcwt_tx #(.TICK_CYCLES(4)) u_hcwt_tx (.CLK_SYS_I, .RESET_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .ENC_SEL_I, .LOW_VOLT_I,
    .DATA_O, .RF_EN_O, .RF_EN_OE_O, .LED_O, .LED_OE_O);
  hcwt_rf_stage u_hcwt_rf_stage (.clk_i(CLK_SYS_I), .rf_en_i(RF_EN_O), .data_i(DATA_O), .pulses_o(pulses),
    .gap_o(gap), .bits_o(rf_bits));
  initial forever #5 CLK_SYS_I = ~CLK_SYS_I;
  // counts indicator flashes
  always @(posedge CLK_SYS_I) begin
    led_q <= LED_OE_O;
    if (LED_OE_O && !led_q) flashes++;
  end
  task close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS_I);
    AVS_READ_I <= !w;
    AVS_WRITE_I <= w;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    @(posedge CLK_SYS_I);
    while (AVS_WAITREQUEST_O !== 1'b0) @(posedge CLK_SYS_I);
    rd = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // press once and wait for the whole transmission
  task xmit(input int exp_pulses, input int gmin, input string what);
    int n;
    n = 0;
    flashes = 0;
    acc(1'b1, 8'h0C, 32'h1);
    while (RF_EN_O !== 1'b1 && n < 50) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    while (RF_EN_O !== 1'b0 && n < 20000) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      $display("mismatch at %0t: transmission did not end", $time);
    end
    chk(pulses, exp_pulses, what);
    chk(gap >= gmin && gap <= gmin + 60, 1, "settle gap");
  endtask
  initial begin
    repeat (40000) @(posedge CLK_SYS_I);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out;
  end
  initial begin
    repeat (8) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    rd_chk(8'h00, 32'h0, "enc0 reset");
    rd_chk(8'h08, 32'h40, "common reset");
    acc(1'b1, 8'h1C, 32'hFFFF);
    rd_chk(8'h1C, 32'h0, "unmapped read");
    $display("register test done");
    // pwm, short header, 6.4 ms guard, shared pin as rf enable, ask
    acc(1'b1, 8'h00, 32'h1);
    acc(1'b1, 8'h08, 32'h44);
    rd_chk(8'h00, 32'h1, "enc0 readback");
    chk(RF_EN_OE_O, 1'b1, "pin drives rf enable");
    acc(1'b1, 8'h14, 32'h1);
    xmit(79, 80, "plain word pulses");
    chk(rf_bits[34:3], 32'h80000000, "fixed code bits");
    chk({29'h0, rf_bits[2:0]}, 32'h2, "low_voltage_flag and crc bits");
    chk(flashes >= 1, 1, "indicator lit");
    $display("single word test done");
    // frame markers, two minimum words, no guard, fsk
    acc(1'b1, 8'h00, 32'h80);
    acc(1'b1, 8'h08, 32'h8C);
    xmit(162, 160, "marked word pulses");
    $display("marker test done");
    // second encoder with queue bits and markers, low supply
    ENC_SEL_I <= 1'b1;
    LOW_VOLT_I <= 1'b1;
    acc(1'b1, 8'h04, 32'h181);
    acc(1'b1, 8'h08, 32'h40);
    rd_chk(8'h04, 32'h181, "enc1 readback");
    chk(RF_EN_OE_O, 1'b0, "pin back to select");
    xmit(83, 80, "queued word pulses");
    chk(flashes, 0, "no blink on low supply");
    $display("second encoder test done");
    close_out;
  end
endmodule
`default_nettype wire
